// ==== rtl/sram_cycle_ctrl.sv ====
// What this block does
// RULE1 - Deselect and tristate on the two select cases
// RULE2 - Sleep high: no access, pins tristated
// RULE3 - All enables, processor strobe low: read burst
// RULE4 - Controller strobe start with write: write burst
// RULE5 - Controller strobe start without write: read burst
// RULE6 - Strobes idle, advance low: next address access
// RULE7 - Advance high: repeat access at current address
// RULE8 - Primary select high ignores processor strobe
// RULE9 - Master never writes on processor strobe start
// RULE10 - Combined write low from gate+lane or global
// RULE11 - Read when global high and no lane write
// RULE12 - Write only selected lanes; global writes all
// RULE13 - Output enable acts on drivers without clocking
// RULE14 - Writes mask output enable, pins stay inputs
// RULE15 - Reads drive pins while output enable low
// RULE16 - Master raises output enable before writes
// RULE17 - Two-bit wrapping counter, linear or interleaved
// RULE18 - Interleaved order by default
// RULE19 - Sleep entry, exit within two cycles, deselected; the sleep decode here follows the pin three edges after it changes
// RULE20 - Master idles two cycles after sleep exit
// RULE21 - Load on begin, step on continue, else hold
`timescale 1ns/10ps
module sram_cycle_ctrl (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Address and chip enables
  input wire logic [sram_pkg::ADDR_W-1:0] ADDR,
  input wire logic PRIMARY_SELECT_N,
  input wire logic SECONDARY_ENABLE_HI,
  input wire logic TERTIARY_ENABLE_N,
  // Burst control
  input wire logic PROCESSOR_STROBE_N,
  input wire logic CONTROLLER_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic ORDER_SELECT,
  // Write control
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_GATE_N,
  input wire logic LANE0_SELECT_N,
  input wire logic LANE1_SELECT_N,
  input wire logic LANE2_SELECT_N,
  input wire logic LANE3_SELECT_N,
  // Asynchronous controls
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  // Data pins, lane k with its parity bit at [9k+8:9k]
  input wire logic [sram_pkg::DATA_W-1:0] DQ_IN,
  output logic [sram_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE
);
  import sram_pkg::*;

  mem_if #(.AW(ADDR_W), .LN(LANES), .LW(LANE_W)) mio ();

  // Pin synchronisers for sleep and burst order
  logic slp_s1_r, slp_s2_r, slp_s3_r, sleep_r, sleep_nxt;
  logic ord_s1_r, ord_s2_r, ord_s3_r, order_r, order_nxt;
  // Burst state
  logic [ADDR_W-1:STEP_W] base_r, base_nxt; // Upper address of burst
  logic [STEP_W-1:0] seed_r, seed_nxt; // First low address bits
  logic [STEP_W-1:0] step_r, step_nxt; // Beats taken so far
  logic live_r, live_nxt; // A burst is open
  logic read_r, read_nxt; // Last cycle was a read
  // Decode of the current edge
  cycle_t cyc_c;
  logic [LANES-1:0] lanes_n; // Lane selects, active low
  logic [LANES-1:0] lanes_c; // Lanes to store on a write
  logic write_c; // Combined write, active high here
  logic cs_all; // All three enables active
  logic desel_c; // Deselect decode

  // Low address bits for a given beat of the burst
  function automatic logic [STEP_W-1:0] burst_low(
    input logic [STEP_W-1:0] seed,
    input logic [STEP_W-1:0] step,
    input logic interleave
  );
    // RULE17 - linear or xor order
    burst_low = interleave ? (seed ^ step) : (seed + step);
  endfunction

  // A synchronised level changes once the last two flops agree
  function automatic logic agreed(
    input logic s2,
    input logic s3,
    input logic prev
  );
    agreed = (s2 == s3) ? s3 : prev;
  endfunction

  // Synchroniser flops only shift; the first is read by the second alone
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slp_s1_r <= SLEEP_RST;
      slp_s2_r <= SLEEP_RST;
      slp_s3_r <= SLEEP_RST;
      ord_s1_r <= ORDER_RST;
      ord_s2_r <= ORDER_RST;
      ord_s3_r <= ORDER_RST;
    end else begin
      slp_s1_r <= SLEEP_REQUEST;
      slp_s2_r <= slp_s1_r;
      slp_s3_r <= slp_s2_r;
      ord_s1_r <= ORDER_SELECT;
      ord_s2_r <= ord_s1_r;
      ord_s3_r <= ord_s2_r;
    end
  end

  // Settled sleep and order levels, used in the same cycle they settle
  always_comb begin
    // RULE19 - sleep follows the pin three edges after it changes
    sleep_nxt = agreed(slp_s2_r, slp_s3_r, sleep_r);
    // RULE18 - order resets to interleaved
    order_nxt = agreed(ord_s2_r, ord_s3_r, order_r);
  end

  // Write decode and cycle selection
  always_comb begin
    lanes_n = {LANE3_SELECT_N, LANE2_SELECT_N, LANE1_SELECT_N,
               LANE0_SELECT_N};
    // RULE10 - combined write indication
    write_c = !GLOBAL_WRITE_N || (!BYTE_WRITE_GATE_N && !(&lanes_n));
    // RULE12 - lane strobes, global writes all
    if (!GLOBAL_WRITE_N) begin
      lanes_c = '1;
    end else if (!BYTE_WRITE_GATE_N) begin
      lanes_c = ~lanes_n;
    end else begin
      // RULE11 - no lane written means a read
      lanes_c = '0;
    end
    cs_all = !PRIMARY_SELECT_N && SECONDARY_ENABLE_HI && !TERTIARY_ENABLE_N;
    // RULE1 - two deselect cases
    desel_c = (PRIMARY_SELECT_N && !CONTROLLER_STROBE_N) ||
              (!PRIMARY_SELECT_N && (!SECONDARY_ENABLE_HI ||
               TERTIARY_ENABLE_N) &&
               (!PROCESSOR_STROBE_N || !CONTROLLER_STROBE_N));
    // RULE2 - sleep overrides every input
    if (sleep_nxt) begin
      cyc_c = CYC_SLEEP;
    end else if (desel_c) begin
      cyc_c = CYC_DESEL;
    end else if (cs_all && !PROCESSOR_STROBE_N) begin
      // RULE3 - processor strobe always reads
      cyc_c = CYC_BEGIN_P;
    end else if (cs_all && !CONTROLLER_STROBE_N) begin
      cyc_c = CYC_BEGIN_C;
    end else if (!BURST_ADVANCE_N) begin
      // RULE8 - primary select high ignores processor strobe
      cyc_c = CYC_CONT;
    end else begin
      cyc_c = CYC_SUSP;
    end
  end

  // Burst counter, memory strobes and read flag
  always_comb begin
    base_nxt = base_r;
    seed_nxt = seed_r;
    step_nxt = step_r;
    live_nxt = live_r;
    read_nxt = 1'b0;
    mio.addr = {base_r, burst_low(seed_r, step_r, order_nxt)};
    mio.we = '0;
    mio.wdata = DQ_IN;
    case (cyc_c)
      CYC_BEGIN_P: begin
        // RULE21 - load on begin
        base_nxt = ADDR[ADDR_W-1:STEP_W];
        seed_nxt = ADDR[STEP_W-1:0];
        step_nxt = STEP_RST;
        live_nxt = 1'b1;
        mio.addr = ADDR;
        // RULE9 - write inputs ignored on this start
        read_nxt = 1'b1;
      end
      CYC_BEGIN_C: begin
        base_nxt = ADDR[ADDR_W-1:STEP_W];
        seed_nxt = ADDR[STEP_W-1:0];
        step_nxt = STEP_RST;
        live_nxt = 1'b1;
        mio.addr = ADDR;
        // RULE4 - write burst start
        mio.we = write_c ? lanes_c : '0;
        // RULE5 - read burst start
        read_nxt = !write_c;
      end
      CYC_CONT: begin
        // A continue with no open burst does nothing
        if (live_r) begin
          // RULE6 - step to next address
          step_nxt = step_r + STEP_INC;
          mio.addr = {base_r, burst_low(seed_r, step_nxt, order_nxt)};
          mio.we = write_c ? lanes_c : '0;
          read_nxt = !write_c;
        end
      end
      CYC_SUSP: begin
        // RULE7 - repeat at current address
        if (live_r) begin
          mio.we = write_c ? lanes_c : '0;
          read_nxt = !write_c;
        end
      end
      CYC_DESEL: begin
        live_nxt = 1'b0;
      end
      default: begin
        // Sleep closes any burst; pending work is dropped
        live_nxt = 1'b0;
      end
    endcase
  end

  // Registers of the cycle control
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sleep_r <= SLEEP_RST;
      order_r <= ORDER_RST;
      base_r <= '0;
      seed_r <= STEP_RST;
      step_r <= STEP_RST;
      live_r <= 1'b0;
      read_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
      order_r <= order_nxt;
      base_r <= base_nxt;
      seed_r <= seed_nxt;
      step_r <= step_nxt;
      live_r <= live_nxt;
      read_r <= read_nxt;
    end
  end

  lane_store #(.AW(ADDR_W), .LN(LANES), .LW(LANE_W)) u_store (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .mio(mio)
  );

  // Read word straight from the array's output register
  assign DQ_OUT = mio.rdata;
  // RULE13 - output enable gates drivers without a flop
  // RULE14 - write cycles keep read_r low
  // RULE15 - drive during reads when enabled
  // Kept combinational on purpose: the pin is asynchronous by nature
  assign DQ_OE = read_r && !OUTPUT_ENABLE_N && !sleep_r;

  // Checks next to the logic they guard
  chk_desel_tristate: assert property ( // RULE1
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_DESEL) |=> !DQ_OE && !live_r)
    else $error("deselect left the pins driven");
  chk_sleep_quiet: assert property ( // RULE2
    @(posedge CORE_CLK) disable iff (!ARST_N)
    sleep_nxt |-> (mio.we == '0) ##1 !DQ_OE)
    else $error("access during sleep");
  chk_pstart_read: assert property ( // RULE3
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (!sleep_nxt && cs_all && !PROCESSOR_STROBE_N) |->
    (mio.addr == ADDR) && (mio.we == '0) ##1 read_r)
    else $error("processor strobe start did not read");
  chk_cstart_write: assert property ( // RULE4
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_BEGIN_C && write_c) |->
    (mio.addr == ADDR) && (mio.we != '0) ##1 !read_r)
    else $error("controller strobe write not stored");
  chk_cstart_read: assert property ( // RULE5
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_BEGIN_C && GLOBAL_WRITE_N && BYTE_WRITE_GATE_N) |=>
    read_r && step_r == STEP_RST)
    else $error("controller strobe read missing");
  chk_cont_step: assert property ( // RULE21
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_CONT && live_r) |=>
    step_r == $past(step_r) + STEP_INC)
    else $error("continue did not advance");
  chk_susp_hold: assert property ( // RULE7
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_SUSP) |=> $stable(step_r) && $stable(base_r))
    else $error("suspend moved the address");
  chk_global_all: assert property ( // RULE12
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (!GLOBAL_WRITE_N && mio.we != '0) |-> mio.we == '1)
    else $error("global write missed a lane");
  chk_oe_mask: assert property ( // RULE14
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (mio.we != '0) |=> !DQ_OE)
    else $error("pins driven after a write");
  chk_read_drive: assert property ( // RULE15
    @(posedge CORE_CLK) disable iff (!ARST_N)
    (cyc_c == CYC_BEGIN_P) |=> (OUTPUT_ENABLE_N || DQ_OE))
    else $error("read not driven while enabled");
endmodule // sram_cycle_ctrl

// ==== rtl/sram_pkg.sv ====
package sram_pkg;
  // Geometry of the array and of one data word
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int STEP_W = 2;

  // Reset values of the synchronised asynchronous pins
  localparam logic SLEEP_RST = 1'b0;
  // Interleaved order is the default, as for a floating order pin
  localparam logic ORDER_RST = 1'b1;
  localparam logic [STEP_W-1:0] STEP_RST = 2'h0;
  localparam logic [STEP_W-1:0] STEP_INC = 2'h1;

  // Cycle decoded at one clock edge
  typedef enum logic [2:0] {
    CYC_SLEEP,
    CYC_DESEL,
    CYC_BEGIN_P,
    CYC_BEGIN_C,
    CYC_CONT,
    CYC_SUSP
  } cycle_t;
endpackage

// ==== rtl/mem_if.sv ====
`timescale 1ns/10ps
// Port of the storage array as seen from the cycle control
interface mem_if #(
  parameter int AW = 17,
  parameter int LN = 4,
  parameter int LW = 9
);
  logic [AW-1:0] addr; // Word address, read and write
  logic [LN-1:0] we; // Per-lane write strobe
  logic [LN*LW-1:0] wdata; // Write word, lane k at [k*LW +: LW]
  logic [LN*LW-1:0] rdata; // Registered read word

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

// ==== rtl/lane_store.sv ====
`timescale 1ns/10ps
// Lane-writable storage array with a registered read port
module lane_store #(
  parameter int AW = 17,
  parameter int LN = 4,
  parameter int LW = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Access port
  mem_if.store mio
);
  // Array contents are not reset, just like the real cells
  logic [LN-1:0][LW-1:0] cells [0:(1<<AW)-1];
  logic [LN*LW-1:0] rdata_r; // Read word register

  // Lane writes; only lanes with a strobe are touched
  always_ff @(posedge clk) begin
    for (int k = 0; k < LN; k++) begin
      if (mio.we[k]) begin
        cells[mio.addr][k] <= mio.wdata[k*LW +: LW];
      end
    end
  end

  // Read every cycle; the word comes out of a register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= cells[mio.addr];
    end
  end

  assign mio.rdata = rdata_r;
endmodule // lane_store

// ==== sim/bus_master.sv ====
`timescale 1ns/10ps
// Data wire as the bus master sees it on the common I/O pins
module bus_master (
  // Clock
  input wire logic clk,
  // Master side
  input wire logic drv,
  input wire logic [sram_pkg::DATA_W-1:0] wdata,
  // Device side
  input wire logic [sram_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [sram_pkg::DATA_W-1:0] dq_in
);
  import sram_pkg::*;
  logic [DATA_W-1:0] last_r = '0; // Level last seen on the wire
  // master drive choice
  // Nobody driving: wire flips every cycle, so stale data never passes
  always_comb begin
    if (drv) dq_in = wdata;
    else if (dq_oe) dq_in = dq_out;
    else dq_in = ~last_r;
  end
  // Track the wire level
  always_ff @(posedge clk) last_r <= dq_in;
endmodule // bus_master

// ==== sim/sync_burst_sram_cycle_control_bench.sv ====
`timescale 1ns/10ps
module sync_burst_sram_cycle_control_bench;
  import sram_pkg::*;
  // Pin drives, all idle at time zero
  logic clk = 1'b0, arst_n = 1'b0, drv = 1'b0, chk = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic primary_select_n = 1, secondary_enable_hi = 1, tertiary_enable_n = 0;
  logic processor_strobe_n = 1, controller_strobe_n = 1, burst_advance_n = 1;
  logic order_select = 1, global_write_n = 1, byte_write_gate_n = 1;
  logic output_enable_n = 1, sleep_request = 0;
  logic [3:0] lane_n = 4'hF; // Lane selects, active low
  logic [DATA_W-1:0] wdata = '0, dq_in, dq_out, exp_q;
  logic dq_oe, exp_rd = 0;
  // Reference model state
  logic [DATA_W-1:0] mem [16];
  bit open = 0;
  int start_w, step, blk, err_total = 0, total_checks = 0;
  int seed = 32'h3A749540;

  sram_cycle_ctrl uut (.CORE_CLK(clk), .ARST_N(arst_n), .ADDR(addr),
    .PRIMARY_SELECT_N(primary_select_n),
    .SECONDARY_ENABLE_HI(secondary_enable_hi),
    .TERTIARY_ENABLE_N(tertiary_enable_n),
    .PROCESSOR_STROBE_N(processor_strobe_n),
    .CONTROLLER_STROBE_N(controller_strobe_n),
    .BURST_ADVANCE_N(burst_advance_n), .ORDER_SELECT(order_select),
    .GLOBAL_WRITE_N(global_write_n), .BYTE_WRITE_GATE_N(byte_write_gate_n),
    .LANE0_SELECT_N(lane_n[0]), .LANE1_SELECT_N(lane_n[1]),
    .LANE2_SELECT_N(lane_n[2]), .LANE3_SELECT_N(lane_n[3]),
    .OUTPUT_ENABLE_N(output_enable_n), .SLEEP_REQUEST(sleep_request),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  bus_master far (.clk(clk), .drv(drv), .wdata(wdata), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));

  // Free-running core clock, 8 ns period
  initial forever #4 clk = ~clk;

  // Ends the run with the verdict
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compare the pin drive enable
  task automatic cmp_oe(input logic e);
    total_checks++;
    if (dq_oe !== e) begin
      err_total++;
      $display("FAIL %0t drive enable %b, want %b", $time, dq_oe, e);
    end
  endtask

  // Compare the read word
  task automatic cmp_q(input logic [DATA_W-1:0] e);
    total_checks++;
    if (dq_out !== e) begin
      err_total++;
      $display("FAIL %0t read word %h, want %h", $time, dq_out, e);
    end
  endtask

  // Reference decode of one rising edge
  task automatic model_edge();
    logic wr, acc;
    int a;
    wr = !global_write_n || (!byte_write_gate_n && lane_n != 4'hF);
    acc = 0;
    exp_rd = 0;
    if (sleep_request) open = 0;
    else if ((primary_select_n && !controller_strobe_n) || (!primary_select_n
      && (!secondary_enable_hi || tertiary_enable_n)
      && !(processor_strobe_n && controller_strobe_n))) open = 0;
    else if (!controller_strobe_n || !(primary_select_n || processor_strobe_n))
    begin
      open = 1;
      blk = {addr[16], addr[2]};
      start_w = addr[1:0];
      step = 0;
      // Processor start always reads
      wr = wr && processor_strobe_n;
      acc = 1;
    end else if (open) begin
      if (!burst_advance_n) step = (step + 1) % 4;
      acc = 1;
    end
    if (acc) begin
      a = blk * 4 + (order_select ? start_w ^ step : (start_w + step) % 4);
      if (wr) begin
        for (int k = 0; k < LANES; k++)
          if (!global_write_n || !lane_n[k])
            mem[a][k*LANE_W +: LANE_W] = dq_in[k*LANE_W +: LANE_W];
      end else begin
        exp_rd = 1;
        exp_q = mem[a];
      end
    end
  endtask

  // One clock with inputs already set at the falling edge
  task automatic cycle();
    #1 if (chk) cmp_oe(exp_rd && !output_enable_n);
    @(posedge clk);
    model_edge();
    @(negedge clk);
    if (chk) cmp_oe(exp_rd && !output_enable_n);
    if (chk && exp_rd) cmp_q(exp_q);
  endtask

  // Strobes off, primary select high: no new burst
  task automatic set_idle();
    primary_select_n = 1;
    secondary_enable_hi = 1;
    tertiary_enable_n = 0;
    processor_strobe_n = 1;
    controller_strobe_n = 1;
    burst_advance_n = 1;
    global_write_n = 1;
    byte_write_gate_n = 1;
    lane_n = 4'hF;
    drv = 0;
  endtask

  // Random mix of every cycle kind except sleep
  task automatic rand_cycle();
    logic [31:0] r, d;
    r = $random(seed);
    d = $random(seed);
    primary_select_n = r[0] & r[1];
    secondary_enable_hi = |r[3:2];
    tertiary_enable_n = &r[5:4];
    processor_strobe_n = r[6];
    controller_strobe_n = r[7];
    burst_advance_n = r[8];
    global_write_n = r[9] | r[10];
    byte_write_gate_n = r[11];
    lane_n = r[15:12];
    addr = {r[16], 13'h0, r[19:17]};
    wdata = {r[31:28], d};
    // never drive on a processor-strobe start
    drv = (primary_select_n || processor_strobe_n) &&
      (!global_write_n || (!byte_write_gate_n && lane_n != 4'hF));
    // enable raised when a write follows a read
    output_enable_n = r[20] | (drv & exp_rd);
    cycle();
  endtask

  // Watchdog, about three times the expected run
  initial begin
    #16000;
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1;
    // Fill all words with controller-start global writes
    for (int i = 0; i < 16; i++) begin
      primary_select_n = 0;
      controller_strobe_n = 0;
      global_write_n = 0;
      drv = 1;
      addr = {i[3], 13'h0, i[2:0]};
      wdata = {4'hA, $random(seed)};
      cycle();
    end
    repeat (300) rand_cycle();
    // Switch to linear order behind a row of deselects
    set_idle();
    controller_strobe_n = 0;
    order_select = 0;
    repeat (6) cycle();
    repeat (300) rand_cycle();
    // Sleep with read starts offered: no access, pins off
    set_idle();
    sleep_request = 1;
    chk = 0;
    repeat (4) cycle();
    chk = 1;
    primary_select_n = 0;
    processor_strobe_n = 0;
    output_enable_n = 0;
    addr = '0;
    repeat (4) cycle();
    set_idle();
    sleep_request = 0;
    repeat (5) cycle();
    primary_select_n = 0;
    processor_strobe_n = 0;
    cycle();
    set_idle();
    cycle();
    complete_run();
  end
endmodule // sync_burst_sram_cycle_control_bench
